// [eim_top.v]
// How it works
// - Bit 14 gates transmit bus error interrupt.
// - Bit 13 gates receive bus error interrupt.
// - Bit 9 gates empty watermark interrupt.
// - Bit 8 gates full watermark interrupt.
// - Bit 7 gates receive done interrupt.
// - Bit 6 gates packet pending interrupt.
// - Bit 5 gates receive activity interrupt.
// - Bit 3 gates transmit done interrupt.
// - Bit 2 gates transmit abort interrupt.
// - Bit 1 gates no receive buffer interrupt.
// - Bit 0 gates receive overflow interrupt.
// - Unassigned bits ignore writes, read zero.
// - Transmit enables affect transmit operations only.
// - Receive enables affect receive operations only.
//
// Top of the Ethernet interrupt enable block with its APB slave.
// Assumes event inputs are one-cycle pulses synchronous to CLK.
`timescale 1ns/100ps
`include "eim_regs.vh"

module eim_top (
  input  wire        CLK,                         // 10 MHz clock
  input  wire        RST_N,                       // async reset, low
  input  wire        PSEL,                        // APB select
  input  wire        PENABLE,                     // APB enable
  input  wire        PWRITE,                      // APB direction
  input  wire [11:0] PADDR,                       // APB byte address
  input  wire [31:0] PWDATA,                      // APB write data
  output reg  [31:0] PRDATA,                      // APB read data
  output reg         PREADY,                      // APB ready
  output reg         PSLVERR,                     // APB error
  input  wire        TX_ACTIVE,                   // transmit in progress
  input  wire        RX_ACTIVE,                   // receive in progress
  input  wire        TRANSMIT_BUS_FAULT,          // event pulse
  input  wire        RECEIVE_BUS_FAULT,           // event pulse
  input  wire        EMPTY_LEVEL_EVENT,           // event pulse
  input  wire        FULL_LEVEL_EVENT,            // event pulse
  input  wire        RECEIVE_COMPLETE_EVENT,      // event pulse
  input  wire        PACKET_WAITING_EVENT,        // event pulse
  input  wire        RECEIVE_ACTIVITY_EVENT,      // event pulse
  input  wire        TRANSMIT_COMPLETE_EVENT,     // event pulse
  input  wire        TRANSMIT_CANCEL_EVENT,       // event pulse
  input  wire        NO_RECEIVE_BUFFER_EVENT,     // event pulse
  input  wire        RECEIVE_FIFO_OVERRUN_EVENT,  // event pulse
  output reg         IRQ                          // interrupt level
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [31:0] enable_reg;
  reg  [31:0] clear_strobe;
  reg  [31:0] next_prdata;
  reg         next_pslverr;
  reg  [31:0] events;
  wire [31:0] flags;
  wire        request;
  wire        setup;

  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = (addr == `EIM_OFS_ENABLE) || (addr == `EIM_OFS_STATUS) ||
                  (addr == `EIM_OFS_CLEAR) || (addr == `EIM_OFS_EVENT);
    end
  endfunction

  always @* begin
    events = 32'h00000000;
    events[`EIM_BIT_TXBUSERR]  = TRANSMIT_BUS_FAULT;
    events[`EIM_BIT_RXBUSERR]  = RECEIVE_BUS_FAULT;
    events[`EIM_BIT_EMPTYLVL]  = EMPTY_LEVEL_EVENT;
    events[`EIM_BIT_FULLLVL]   = FULL_LEVEL_EVENT;
    events[`EIM_BIT_RECEIVE_COMPLETE_EVENT]    = RECEIVE_COMPLETE_EVENT;
    events[`EIM_BIT_PKTWAIT]   = PACKET_WAITING_EVENT;
    events[`EIM_BIT_RECEIVE_ACTIVITY_EVENT]     = RECEIVE_ACTIVITY_EVENT;
    events[`EIM_BIT_TRANSMIT_COMPLETE_EVENT]    = TRANSMIT_COMPLETE_EVENT;
    events[`EIM_BIT_TXCANCEL]  = TRANSMIT_CANCEL_EVENT;
    events[`EIM_BIT_NORXBUF]   = NO_RECEIVE_BUFFER_EVENT;
    events[`EIM_BIT_RXOVERRUN] = RECEIVE_FIFO_OVERRUN_EVENT;
  end

  eim_sticky #(
    .WIDTH (32)
  ) u_sticky (
    .clk      (CLK),
    .rst_n    (RST_N),
    .set_bits (events),
    .clr_bits (clear_strobe),
    .flags    (flags)
  );

  eim_gate u_gate (
    .flags     (flags),
    .enables   (enable_reg),
    .tx_active (TX_ACTIVE),
    .rx_active (RX_ACTIVE),
    .request   (request)
  );

  // Setup phase: answer one cycle later with PREADY for one cycle.
  assign setup = PSEL && !PENABLE && (state == ST_IDLE);

  always @* begin
    case (state)
      ST_IDLE: begin
        next_state = setup ? ST_RESP : ST_IDLE;
      end
      ST_RESP: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (setup && !PWRITE) begin
      case (PADDR)
        `EIM_OFS_ENABLE: begin
          next_prdata = enable_reg & `EIM_EN_MASK;
        end
        `EIM_OFS_STATUS: begin
          next_prdata = flags;
        end
        `EIM_OFS_EVENT: begin
          next_prdata = flags & enable_reg;
        end
        default: begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
    if (setup && !is_mapped(PADDR)) begin
      next_pslverr = 1'b1;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state        <= ST_IDLE;
      enable_reg   <= `EIM_RESET_VALUE;
      clear_strobe <= 32'h00000000;
      PRDATA       <= 32'h00000000;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      IRQ          <= 1'b0;
    end else begin
      state        <= next_state;
      clear_strobe <= 32'h00000000;
      PREADY       <= setup;
      PSLVERR      <= next_pslverr;
      PRDATA       <= next_prdata;
      if (setup && PWRITE && (PADDR == `EIM_OFS_ENABLE)) begin
        // Bits 14,13,9..5,3..0 are kept; the rest are dropped.
        enable_reg <= PWDATA & `EIM_EN_MASK;
      end
      if (setup && PWRITE && (PADDR == `EIM_OFS_CLEAR)) begin
        clear_strobe <= PWDATA & `EIM_EN_MASK;
      end
      IRQ <= request;
    end
  end
endmodule

// [eim_regs.vh]
// Register map and field layout of the Ethernet interrupt enable block.
// Assumes a 32-bit APB with one aligned word per register.
`ifndef EIM_REGS_VH
`define EIM_REGS_VH

`define EIM_ADDR_W         12
`define EIM_OFS_ENABLE     12'h000
`define EIM_OFS_STATUS     12'h004
`define EIM_OFS_CLEAR      12'h008
`define EIM_OFS_EVENT      12'h00C

`define EIM_BIT_TXBUSERR   14
`define EIM_BIT_RXBUSERR   13
`define EIM_BIT_EMPTYLVL   9
`define EIM_BIT_FULLLVL    8
`define EIM_BIT_RECEIVE_COMPLETE_EVENT     7
`define EIM_BIT_PKTWAIT    6
`define EIM_BIT_RECEIVE_ACTIVITY_EVENT      5
`define EIM_BIT_TRANSMIT_COMPLETE_EVENT     3
`define EIM_BIT_TXCANCEL   2
`define EIM_BIT_NORXBUF    1
`define EIM_BIT_RXOVERRUN  0

`define EIM_EN_MASK        32'h000063EF
`define EIM_TX_MASK        32'h0000400C
`define EIM_RX_MASK        32'h000023E3
`define EIM_RESET_VALUE    32'h00000000

`endif

// [eim_sticky.v]
// Sticky event latches: an event sets its bit, a write of one clears it.
// Assumes events and clears are synchronous to CLK.
`timescale 1ns/100ps
`include "eim_regs.vh"

module eim_sticky #(
  parameter WIDTH = 32
) (
  input  wire             clk,        // clock
  input  wire             rst_n,      // async reset, low
  input  wire [WIDTH-1:0] set_bits,   // event pulses
  input  wire [WIDTH-1:0] clr_bits,   // clear strobes
  output reg  [WIDTH-1:0] flags       // sticky flags
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Set wins over a clear in the same cycle.
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags[i] <= 1'b0;
        end else if (set_bits[i]) begin
          flags[i] <= 1'b1;
        end else if (clr_bits[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// [eim_gate.v]
// Gates event flags with their enable bits into one request level.
// Assumes flags and enables are registered upstream.
`timescale 1ns/100ps
`include "eim_regs.vh"

module eim_gate (
  input  wire [31:0] flags,      // event flags
  input  wire [31:0] enables,    // enable bits
  input  wire        tx_active,  // transmit path in use
  input  wire        rx_active,  // receive path in use
  output wire        request     // gated request
);
  wire [31:0] tx_gate;
  wire [31:0] rx_gate;

  // Transmit enables act only while transmitting.
  assign tx_gate = {32{tx_active}} & `EIM_TX_MASK;
  // Receive enables act only while receiving.
  assign rx_gate = {32{rx_active}} & `EIM_RX_MASK;
  assign request = |(flags & enables & (tx_gate | rx_gate));
endmodule

// [eim_asserts.sv]
// Port checker for the interrupt enable block.
// Assumes it is bound into eim_top.
`timescale 1ns/100ps
`include "eim_regs.vh"
module eim_chk (
  input wire        CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, // bus and request
  input wire        TX_ACTIVE, RX_ACTIVE, TRANSMIT_BUS_FAULT,                // paths and one event
  input wire [11:0] PADDR,                                                   // address
  input wire [31:0] PWDATA, PRDATA                                           // data
);
  reg [31:0] en_s;
  always @(posedge CLK or negedge RST_N)
    if (!RST_N)
      en_s <= 32'h0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `EIM_OFS_ENABLE)
      en_s <= PWDATA & `EIM_EN_MASK;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  setup_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("long ready");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("stray data");
  unmapped_err_a: assert property (PREADY && PADDR[11:4] != 8'h0 |-> PSLVERR)
    else $error("no error");
  enable_read_a: assert property (PREADY && !PWRITE && PADDR == `EIM_OFS_ENABLE |-> PRDATA == en_s)
    else $error("bad enable");
  idle_path_a: assert property ((!TX_ACTIVE && !RX_ACTIVE) [*3] |-> !IRQ)
    else $error("idle request");
  tx_fault_a: assert property (TRANSMIT_BUS_FAULT && en_s[14] && TX_ACTIVE ##1 TX_ACTIVE |-> ##[0:1] IRQ)
    else $error("no request");
  reset_quiet_a: assert property ($rose(RST_N) |-> !IRQ && !PREADY)
    else $error("busy at reset");
endmodule
bind eim_top eim_chk eim_chk_i (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PREADY, .PSLVERR, .IRQ,
  .TX_ACTIVE, .RX_ACTIVE, .TRANSMIT_BUS_FAULT, .PADDR, .PWDATA, .PRDATA);

// [eim_intc.sv]
// Host interrupt controller model counting requests.
// Assumes a level request on CLK.
`timescale 1ns/100ps
module eim_intc (
  input  wire       CLK,   // clock
  input  wire       RST_N, // reset
  input  wire       IRQ,   // request
  output reg  [7:0] hits   // count
);
  reg seen;
  always @(posedge CLK or negedge RST_N)
    if (!RST_N)
      {seen, hits} <= 9'h0;
    else begin
      seen <= IRQ;
      if (IRQ && !seen)
        hits <= hits + 8'h1;
    end
endmodule

// [tb_top.sv]
// Bench for the interrupt enable block.
// Assumes eim_top, its checker and eim_intc.
`timescale 1ns/100ps
`include "eim_regs.vh"
module tb_top;
  reg         CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, txa = 0, rxa = 0, s, r;
  reg  [11:0] PADDR = 0;
  reg  [31:0] PWDATA = 0, q, en;
  reg  [14:0] ev = 0;
  wire [31:0] PRDATA;
  wire        PREADY, PSLVERR, IRQ;
  wire [7:0]  hits;
  integer     num_errors = 0, n_compared = 0, i, t, b, n, irqs = 0;
  int         bits [11] = '{14, 13, 9, 8, 7, 6, 5, 3, 2, 1, 0};
  eim_top eim_top_i (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .TX_ACTIVE(txa), .RX_ACTIVE(rxa), .TRANSMIT_BUS_FAULT(ev[14]), .RECEIVE_BUS_FAULT(ev[13]),
    .EMPTY_LEVEL_EVENT(ev[9]), .FULL_LEVEL_EVENT(ev[8]), .RECEIVE_COMPLETE_EVENT(ev[7]),
    .PACKET_WAITING_EVENT(ev[6]), .RECEIVE_ACTIVITY_EVENT(ev[5]), .TRANSMIT_COMPLETE_EVENT(ev[3]),
    .TRANSMIT_CANCEL_EVENT(ev[2]), .NO_RECEIVE_BUFFER_EVENT(ev[1]), .RECEIVE_FIFO_OVERRUN_EVENT(ev[0]), .IRQ);
  eim_intc eim_intc_i (.CLK, .RST_N, .IRQ, .hits);
  initial forever #50 CLK = ~CLK;
  function exp_irq(input integer k, input [31:0] v, input tx, rx);
    exp_irq = v[k] && ((k == 14 || k == 3 || k == 2) ? tx : rx);
  endfunction
  task chk(input [31:0] got, exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("FAIL %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge CLK);
      PSEL <= 1;
      PENABLE <= 0;
      PADDR <= a;
      PWRITE <= w;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      n = 0;
      do begin
        @(posedge CLK);
        {r, s, q} = {PREADY, PSLVERR, PRDATA};
        n = n + 1;
        if (n > 16)
          chk(0, 1);
        if (n > 16)
          complete_run;
      end while (!r);
      PSEL <= 0;
      PENABLE <= 0;
    end
  endtask
  initial begin
    n = $urandom(32'h3EC8D99C);
    repeat (6) @(posedge CLK);
    RST_N <= 1;
    apb(`EIM_OFS_ENABLE, 0, 0);
    chk(q, `EIM_RESET_VALUE);
    apb(`EIM_OFS_ENABLE, 1, 32'hFFFFFFFF);
    apb(`EIM_OFS_ENABLE, 0, 0);
    chk(q, `EIM_EN_MASK);
    apb(12'h040, 0, 0);
    chk({q[31:1], s}, 32'h1);
    $display("register test done");
    for (i = 0; i < 44; i = i + 1) begin
      b = bits[i % 11];
      t = i / 11;
      en = t ? $urandom : 32'hFFFFFFFF;
      apb(`EIM_OFS_ENABLE, 1, en);
      txa <= t ? $urandom % 2 : 1;
      rxa <= t ? $urandom % 2 : 1;
      ev[b] <= 1;
      @(posedge CLK);
      ev[b] <= 0;
      repeat (3) @(posedge CLK);
      @(negedge CLK);
      chk(IRQ, exp_irq(b, en, txa, rxa));
      irqs = irqs + exp_irq(b, en, txa, rxa);
      apb(`EIM_OFS_STATUS, 0, 0);
      chk(q, 32'h1 << b);
      apb(`EIM_OFS_EVENT, 0, 0);
      chk(q, en & (32'h1 << b));
      apb(`EIM_OFS_CLEAR, 1, 32'hFFFFFFFF);
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      chk(IRQ, 0);
    end
    $display("gating test done");
    chk(hits, irqs);
    complete_run;
  end
endmodule
